// *** cpu_cfg_pkg.sv ***
// Types shared by the core status and mode configuration block
package cpu_cfg_pkg;

  typedef enum logic [4:0] {
    BOOT_SYNC = 5'h01,
    BOOT_MODE_REQ = 5'h02,
    BOOT_VEC_REQ = 5'h04,
    BOOT_RUN = 5'h08,
    BOOT_UNUSED = 5'h10
  } boot_state_t;

  typedef enum logic [2:0] {
    PUSH_IDLE = 3'h1,
    PUSH_STATUS = 3'h2,
    PUSH_COUNTER = 3'h4
  } push_state_t;

endpackage

// *** cpu_cfg_regs.svh ***
// Register offsets, field positions and reset values of the core status block
`ifndef CPU_CFG_REGS_SVH
`define CPU_CFG_REGS_SVH

`define OFS_PROGRAM_STATUS 12'h000
`define OFS_VECTOR_TABLE_BASE 12'h004
`define OFS_RETURN_POINTER 12'h008
`define OFS_SYSTEM_STACK 12'h00c
`define OFS_USER_STACK 12'h010
`define OFS_STACK_ALIAS 12'h014
`define OFS_PROGRAM_COUNTER 12'h018
`define OFS_BOOT_STATUS 12'h01c
`define OFS_MODE_BYTE 12'h7fd
`define OFS_MODE_HOLE 12'h7ff

`define PS_ILM_LSB 16
`define PS_ILM_MSB 20
`define PS_DIV_HI_BIT 10
`define PS_DIV_LO_BIT 9
`define PS_TRACE_BIT 8
`define PS_STACK_SEL_BIT 5
`define PS_INT_EN_BIT 4
`define PS_WRITE_MASK 32'h001f073f

`define MODE_RAM_EN_BIT 2
`define MODE_WIDTH_MSB 1
`define MODE_RESERVED_MSB 7
`define MODE_RESERVED_LSB 3

`define ILM_RESET 5'h0f
`define TBR_RESET 32'h000ffc00
`define SSP_RESET 32'h00000000
`define MODE_RESET 8'h00
`define EXT_VECTOR_PINS 3'h1

`define MODE_VECTOR_ADDR 32'h000ffff8
`define RESET_VECTOR_ADDR 32'h000ffffc
`define EIT_FRAME_BYTES 32'h00000008
`define WORD_BYTES 32'h00000004
`define DIRECT_BYTE_LAST 10'h0ff
`define DIRECT_WORD_LAST 10'h3ff
`define SYNC_WAIT_CYCLES 2'h2

`endif

// *** cpu_status_and_mode_config.sv ***
// Core dedicated registers, boot mode fetch and mode byte
// Functional notes
// - General register fifteen reads zero after reset
// - Reserved status bits read zero, ignore writes
// - Reset clears stack-select and interrupt-enable flags
// - Interrupt level mask resets to fifteen
// - Vector table base takes its reset value
// - Call copies program counter to return pointer
// - Return loads program counter from return pointer
// - Register fifteen follows the stack-select flag
// - Exception entry pushes status and counter on system stack
// - System stack pointer resets to zero
// - Step trace flag enables per-instruction trap
// - Division flags hold between division steps
// - External vector pins fetch reset vector outside
// - Mode fetch writes the mode byte
// - Mode byte loads only during reset sequence
// - Mode bit two enables on-chip RAM
// - Low mode bits encode bus width
// - External mode copies width to area zero
// - Address two above mode byte reads nothing
// - Boot reads mode vector, then reset vector
`timescale 1ns/1ns
`default_nettype none
`include "cpu_cfg_regs.svh"

module cpu_status_and_mode_config
  import cpu_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mode_pin_two,
  input wire logic mode_pin_one,
  input wire logic mode_pin_zero,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  output logic fetch_external,
  input wire logic fetch_ack,
  input wire logic [31:0] fetch_data,
  output logic boot_done,
  input wire logic pc_we,
  input wire logic [31:0] pc_in,
  input wire logic call_exec,
  input wire logic ret_exec,
  input wire logic cc_we,
  input wire logic [3:0] cc_in,
  input wire logic div_step,
  input wire logic [1:0] div_flags_in,
  input wire logic eit_entry,
  output logic push_we,
  output logic [31:0] push_addr,
  output logic [31:0] push_data,
  output logic [31:0] program_counter,
  output logic [4:0] interrupt_level_mask,
  output logic stack_select,
  output logic interrupt_enable,
  output logic step_trace_enable,
  output logic [7:0] operating_mode_byte,
  output logic onchip_ram_enable,
  output logic [1:0] area_width_field,
  input wire logic [9:0] dir_addr,
  input wire logic dir_word,
  output logic dir_in_window
);

  // ************************************************************
  // Registers and mode pin synchroniser
  // ************************************************************
  logic [4:0] ilm_q;
  logic [2:0] scr_q;
  logic [5:0] ccr_q;
  logic [31:0] tbr_q;
  logic [31:0] rp_q;
  logic [31:0] ssp_q;
  logic [31:0] usp_q;
  logic [31:0] pc_q;
  logic [7:0] mode_q;
  logic [1:0] width_q;
  logic [2:0] pins_meta_q;
  logic [2:0] pins_q;
  logic [1:0] sync_cnt_q;
  logic ext_q;
  boot_state_t boot_q;
  push_state_t push_q;
  logic [31:0] push_addr_q;
  logic [31:0] push_data_q;
  logic [31:0] ps_frame_q;
  logic [31:0] rdata_q;
  logic [31:0] ps_value;
  logic wr_ps;
  logic wr_alias;

  // Pins are asynchronous straps; only the second stage is read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_meta_q <= 3'h0;
      pins_q <= 3'h0;
    end
    else
    begin
      pins_meta_q <= {mode_pin_two, mode_pin_one, mode_pin_zero};
      pins_q <= pins_meta_q;
    end
  end

  assign ps_value = {11'h000, ilm_q, 5'h00, scr_q, 2'h0, ccr_q};
  assign wr_ps = reg_wr && (reg_addr == `OFS_PROGRAM_STATUS);
  assign wr_alias = reg_wr && (reg_addr == `OFS_STACK_ALIAS);

  // ************************************************************
  // Boot sequence: mode vector, then reset vector
  // ************************************************************
  // fixed vector order
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_q <= BOOT_SYNC;
      sync_cnt_q <= 2'h0;
      ext_q <= 1'b0;
    end
    else
    begin
      case (boot_q)
        BOOT_SYNC:
        begin
          // Wait until the strap has crossed both stages
          if (sync_cnt_q == `SYNC_WAIT_CYCLES)
          begin
            boot_q <= BOOT_MODE_REQ;
            ext_q <= (pins_q == `EXT_VECTOR_PINS);
          end
          else
          begin
            sync_cnt_q <= sync_cnt_q + 2'h1;
          end
        end
        BOOT_MODE_REQ:
        begin
          if (fetch_ack)
          begin
            boot_q <= BOOT_VEC_REQ;
          end
        end
        BOOT_VEC_REQ:
        begin
          if (fetch_ack)
          begin
            boot_q <= BOOT_RUN;
          end
        end
        BOOT_RUN:
        begin
          boot_q <= BOOT_RUN;
        end
        default:
        begin
          boot_q <= BOOT_SYNC;
        end
      endcase
    end
  end

  assign fetch_req = (boot_q == BOOT_MODE_REQ) || (boot_q == BOOT_VEC_REQ);
  assign fetch_addr = (boot_q == BOOT_VEC_REQ) ? `RESET_VECTOR_ADDR : `MODE_VECTOR_ADDR;
  assign fetch_external = ext_q;
  assign boot_done = (boot_q == BOOT_RUN);

  // ************************************************************
  // Mode byte and area zero width
  // ************************************************************
  // mode fetch loads byte
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= `MODE_RESET;
    end
    else if ((boot_q == BOOT_MODE_REQ) && fetch_ack)
    begin
      mode_q <= fetch_data[31:24];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      width_q <= 2'h0;
    end
    else if ((boot_q == BOOT_MODE_REQ) && fetch_ack && ext_q)
    begin
      width_q <= fetch_data[25:24];
    end
  end

  assign operating_mode_byte = mode_q;
  assign onchip_ram_enable = mode_q[`MODE_RAM_EN_BIT];
  assign area_width_field = width_q;

  // ************************************************************
  // Program counter and return pointer
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_q <= 32'h0;
    end
    else if ((boot_q == BOOT_VEC_REQ) && fetch_ack)
    begin
      pc_q <= fetch_data;
    end
    else if (ret_exec)
    begin
      pc_q <= rp_q;
    end
    else if (pc_we)
    begin
      pc_q <= pc_in;
    end
    else if (reg_wr && (reg_addr == `OFS_PROGRAM_COUNTER))
    begin
      pc_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rp_q <= 32'h0;
    end
    else if (call_exec)
    begin
      rp_q <= pc_q;
    end
    else if (reg_wr && (reg_addr == `OFS_RETURN_POINTER))
    begin
      rp_q <= reg_wdata;
    end
  end

  // ************************************************************
  // Program status
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ilm_q <= `ILM_RESET;
      scr_q <= 3'h0;
      ccr_q <= 6'h00;
    end
    else
    begin
      if (wr_ps)
      begin
        ilm_q <= reg_wdata[`PS_ILM_MSB:`PS_ILM_LSB];
        scr_q <= reg_wdata[`PS_DIV_HI_BIT:`PS_TRACE_BIT];
        ccr_q <= reg_wdata[5:0];
      end
      else
      begin
        if (div_step)
        begin
          scr_q[2:1] <= div_flags_in;
        end
        if (cc_we)
        begin
          ccr_q[3:0] <= cc_in;
        end
      end
    end
  end

  assign interrupt_level_mask = ilm_q;
  assign stack_select = ccr_q[`PS_STACK_SEL_BIT];
  assign interrupt_enable = ccr_q[`PS_INT_EN_BIT];
  assign step_trace_enable = scr_q[0];
  assign program_counter = pc_q;

  // ************************************************************
  // Stack pointers and exception push
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ssp_q <= `SSP_RESET;
    end
    else if (eit_entry && (push_q == PUSH_IDLE))
    begin
      ssp_q <= ssp_q - `EIT_FRAME_BYTES;
    end
    else if ((reg_wr && (reg_addr == `OFS_SYSTEM_STACK)) || (wr_alias && !stack_select))
    begin
      ssp_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      usp_q <= 32'h0;
    end
    else if ((reg_wr && (reg_addr == `OFS_USER_STACK)) || (wr_alias && stack_select))
    begin
      usp_q <= reg_wdata;
    end
  end

  // Entries arriving mid-push are dropped; core issues one per frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_q <= PUSH_IDLE;
      push_addr_q <= 32'h0;
      push_data_q <= 32'h0;
      ps_frame_q <= 32'h0;
    end
    else
    begin
      case (push_q)
        PUSH_IDLE:
        begin
          if (eit_entry)
          begin
            push_q <= PUSH_STATUS;
            push_addr_q <= ssp_q - `WORD_BYTES;
            push_data_q <= ps_value;
            ps_frame_q <= pc_q;
          end
        end
        PUSH_STATUS:
        begin
          push_q <= PUSH_COUNTER;
          push_addr_q <= push_addr_q - `WORD_BYTES;
          push_data_q <= ps_frame_q;
        end
        default:
        begin
          push_q <= PUSH_IDLE;
        end
      endcase
    end
  end

  assign push_we = (push_q != PUSH_IDLE);
  assign push_addr = push_addr_q;
  assign push_data = push_data_q;

  assign dir_in_window = dir_word ? (dir_addr <= `DIRECT_WORD_LAST) :
                         (dir_addr <= `DIRECT_BYTE_LAST);

  // ************************************************************
  // Register read port
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `OFS_PROGRAM_STATUS: rdata_q <= ps_value;
        `OFS_VECTOR_TABLE_BASE: rdata_q <= tbr_q;
        `OFS_RETURN_POINTER: rdata_q <= rp_q;
        `OFS_SYSTEM_STACK: rdata_q <= ssp_q;
        `OFS_USER_STACK: rdata_q <= usp_q;
        // alias reads system stack after reset
        `OFS_STACK_ALIAS: rdata_q <= stack_select ? usp_q : ssp_q;
        `OFS_PROGRAM_COUNTER: rdata_q <= pc_q;
        `OFS_BOOT_STATUS: rdata_q <= {27'h0, ext_q, pins_q, boot_done};
        `OFS_MODE_BYTE: rdata_q <= {24'h0, mode_q};
        `OFS_MODE_HOLE: rdata_q <= 32'h0;
        default: rdata_q <= 32'h0;
      endcase
    end
    else
    begin
      rdata_q <= 32'h0;
    end
  end

  assign reg_rdata = rdata_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbr_q <= `TBR_RESET;
    end
    else if (reg_wr && (reg_addr == `OFS_VECTOR_TABLE_BASE))
    begin
      tbr_q <= reg_wdata;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_call_saves_pc: assert property (call_exec |=> rp_q == $past(pc_q))
    else $error("return pointer missed program counter on call");
  a_ret_loads_pc: assert property (ret_exec && boot_done |=> pc_q == $past(rp_q))
    else $error("program counter not loaded on return");
  a_ps_reserved_zero: assert property (reg_rd && reg_addr == `OFS_PROGRAM_STATUS
    |=> (reg_rdata & ~`PS_WRITE_MASK) == 32'h0)
    else $error("reserved status bits not zero");
  a_mode_sw_locked: assert property (reg_wr && boot_done |=> $stable(mode_q))
    else $error("mode byte changed after boot");
  a_mode_fetch_load: assert property (boot_q == BOOT_MODE_REQ && fetch_ack
    |=> mode_q == $past(fetch_data[31:24]) && fetch_addr == `RESET_VECTOR_ADDR)
    else $error("mode byte not taken from fetch");
  a_alias_read: assert property (reg_rd && reg_addr == `OFS_STACK_ALIAS
    |=> reg_rdata == $past(stack_select ? usp_q : ssp_q))
    else $error("stack alias read wrong pointer");
  a_eit_push_pair: assert property (push_q == PUSH_IDLE && eit_entry
    |=> push_we && push_data == $past(ps_value) ##1 push_we
    && push_addr == $past(ssp_q, 2) - `EIT_FRAME_BYTES ##1 !push_we)
    else $error("exception frame push wrong");
  a_div_flags_hold: assert property (!div_step && !wr_ps |=> $stable(scr_q[2:1]))
    else $error("division flags changed without a step");
  a_width_copy: assert property (boot_q == BOOT_MODE_REQ && fetch_ack && ext_q
    |=> area_width_field == $past(fetch_data[25:24]))
    else $error("area zero width not copied");
  a_hole_reads_zero: assert property (reg_rd && reg_addr == `OFS_MODE_HOLE
    |=> reg_rdata == 32'h0)
    else $error("empty location returned data");

  c_external_boot: cover property (boot_q == BOOT_VEC_REQ && fetch_ack && ext_q);
  c_call_then_ret: cover property (call_exec ##[1:20] ret_exec);
  c_eit_push: cover property (push_q == PUSH_COUNTER);
  c_user_alias: cover property (wr_alias && stack_select);

endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the core status and mode configuration block
`timescale 1ns/1ns
`default_nettype none
`include "cpu_cfg_regs.svh"

module tb;
  import cpu_cfg_pkg::*;

  // ****************************************
  // Signals and design instance
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] pins = 3'h1;
  logic fetch_req, fetch_external, fetch_ack = 1'b0, boot_done, push_we;
  logic [31:0] fetch_addr, fetch_data = 32'h0, push_addr, push_data, program_counter;
  logic pc_we = 1'b0, call_exec = 1'b0, ret_exec = 1'b0, cc_we = 1'b0;
  logic div_step = 1'b0, eit_entry = 1'b0, dir_word = 1'b0, dir_in_window;
  logic [31:0] pc_in = 32'h0;
  logic [3:0] cc_in = 4'h0;
  logic [1:0] div_flags_in = 2'h0, area_width_field;
  logic [4:0] interrupt_level_mask;
  logic stack_select, interrupt_enable, step_trace_enable, onchip_ram_enable;
  logic [7:0] operating_mode_byte;
  logic [9:0] dir_addr = 10'h000;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] rd_q;

  cpu_status_and_mode_config DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mode_pin_two(pins[2]), .mode_pin_one(pins[1]), .mode_pin_zero(pins[0]),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_external(fetch_external),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .boot_done(boot_done),
    .pc_we(pc_we), .pc_in(pc_in), .call_exec(call_exec), .ret_exec(ret_exec),
    .cc_we(cc_we), .cc_in(cc_in), .div_step(div_step), .div_flags_in(div_flags_in),
    .eit_entry(eit_entry), .push_we(push_we), .push_addr(push_addr),
    .push_data(push_data), .program_counter(program_counter),
    .interrupt_level_mask(interrupt_level_mask), .stack_select(stack_select),
    .interrupt_enable(interrupt_enable), .step_trace_enable(step_trace_enable),
    .operating_mode_byte(operating_mode_byte), .onchip_ram_enable(onchip_ram_enable),
    .area_width_field(area_width_field), .dir_addr(dir_addr), .dir_word(dir_word),
    .dir_in_window(dir_in_window)
  );

  initial
  begin
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
    check(rd_q, exp);
  endtask

  task automatic fetch(input logic [31:0] addr, input logic [31:0] d);
    for (int i = 0; i < 20; i++)
    begin
      if (fetch_req === 1'b1)
        break;
      @(posedge clk);
      #1;
    end
    check({31'h0, fetch_req}, 32'h1);
    check(fetch_addr, addr);
    @(posedge clk);
    fetch_ack <= 1'b1;
    fetch_data <= d;
    @(posedge clk);
    fetch_ack <= 1'b0;
    fetch_data <= ~d;
    #1;
  endtask

  task automatic boot(input logic [2:0] p, input logic [7:0] m, input logic ext,
                      input logic [1:0] w);
    @(posedge clk);
    pins <= p;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({27'h0, interrupt_level_mask}, 32'h0f);
    fetch(`MODE_VECTOR_ADDR, {m, 24'h0});
    check({31'h0, fetch_external}, {31'h0, ext});
    fetch(`RESET_VECTOR_ADDR, {24'h001000, m});
    check({31'h0, boot_done}, 32'h1);
    check(program_counter, {24'h001000, m});
    check({24'h0, operating_mode_byte}, {24'h0, m});
    check({31'h0, onchip_ram_enable}, {31'h0, m[2]});
    check({30'h0, area_width_field}, {30'h0, w});
    rd(`OFS_PROGRAM_STATUS, 32'h000f0000);
    rd(`OFS_VECTOR_TABLE_BASE, `TBR_RESET);
    rd(`OFS_SYSTEM_STACK, `SSP_RESET);
    rd(`OFS_STACK_ALIAS, 32'h0);
    rd(`OFS_MODE_BYTE, {24'h0, m});
    rd(`OFS_BOOT_STATUS, {27'h0, ext, p, 1'b1});
    wr(`OFS_MODE_BYTE, ~{24'h0, m});
    rd(`OFS_MODE_BYTE, {24'h0, m});
    rd(`OFS_MODE_HOLE, 32'h0);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk);
    // Width 01 with RAM on, then reserved bits and a barred width, then not external
    // first and last mode bytes keep upper bits zero
    boot(3'h1, 8'h05, 1'b1, 2'h1);
    boot(3'h1, 8'hfa, 1'b1, 2'h2);
    boot(3'h0, 8'h01, 1'b0, 2'h0);
    rd(12'h020, 32'h0);
    rd(`OFS_VECTOR_TABLE_BASE, `TBR_RESET);
    // Read data stand one cycle only, then fall back to zero
    @(posedge clk);
    #1;
    check(reg_rdata, 32'h0);
    wr(`OFS_PROGRAM_STATUS, 32'hffffffff);
    rd(`OFS_PROGRAM_STATUS, `PS_WRITE_MASK);
    check({27'h0, interrupt_level_mask}, 32'h1f);
    check({29'h0, stack_select, interrupt_enable, step_trace_enable}, 32'h7);
    wr(`OFS_STACK_ALIAS, 32'h00000200);
    rd(`OFS_USER_STACK, 32'h00000200);
    rd(`OFS_SYSTEM_STACK, 32'h0);
    wr(`OFS_PROGRAM_STATUS, 32'h0);
    wr(`OFS_STACK_ALIAS, 32'h00000100);
    rd(`OFS_SYSTEM_STACK, 32'h00000100);
    rd(`OFS_STACK_ALIAS, 32'h00000100);
    // Flags from the core, division flags must survive a later flag update
    @(posedge clk);
    div_step <= 1'b1;
    div_flags_in <= 2'h2;
    @(posedge clk);
    div_step <= 1'b0;
    cc_we <= 1'b1;
    cc_in <= 4'h9;
    @(posedge clk);
    cc_we <= 1'b0;
    rd(`OFS_PROGRAM_STATUS, 32'h00000409);
    // Call and return
    @(posedge clk);
    pc_we <= 1'b1;
    pc_in <= 32'h00001234;
    @(posedge clk);
    pc_we <= 1'b0;
    call_exec <= 1'b1;
    @(posedge clk);
    call_exec <= 1'b0;
    pc_we <= 1'b1;
    pc_in <= 32'h00005678;
    @(posedge clk);
    pc_we <= 1'b0;
    rd(`OFS_RETURN_POINTER, 32'h00001234);
    rd(`OFS_PROGRAM_COUNTER, 32'h00005678);
    @(posedge clk);
    ret_exec <= 1'b1;
    @(posedge clk);
    ret_exec <= 1'b0;
    #1;
    check(program_counter, 32'h00001234);
    // Exception frame: status at ssp-4, counter at ssp-8
    @(posedge clk);
    eit_entry <= 1'b1;
    @(posedge clk);
    eit_entry <= 1'b0;
    #1;
    check({push_we, push_addr[30:0]}, 32'h800000fc);
    check(push_data, 32'h00000409);
    @(posedge clk);
    #1;
    check({push_we, push_addr[30:0]}, 32'h800000f8);
    check(push_data, 32'h00001234);
    @(posedge clk);
    #1;
    check({31'h0, push_we}, 32'h0);
    rd(`OFS_SYSTEM_STACK, 32'h000000f8);
    // Direct windows: edges of byte and word ranges
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      dir_word <= i[1];
      dir_addr <= i[0] ? 10'h100 : (i[1] ? `DIRECT_WORD_LAST : `DIRECT_BYTE_LAST);
      #1;
      check({31'h0, dir_in_window}, {31'h0, (i != 1)});
    end
    finish_test();
  end

  initial
  begin
    #200000;
    n_errors++;
    finish_test();
  end

endmodule
`default_nettype wire
